// ==== design/nvc_pkg.sv ====
// nvc_pkg: constants for the nonvolatile sram host controller
// assumes a 20 MHz system clock
package nvc_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    // operation times
    localparam int NV_SAVE_DURATION_MS = 10;
    localparam int NV_RESTORE_DURATION_US = 20;
    localparam int POWERUP_RESTORE_DURATION_US = 550;
    localparam int CYCLE_FINISH_ALLOWANCE_US = 1;
    localparam int INHIBIT_RELEASE_TIME_NS = 700;
    localparam int BUSY_PULSE_NS = 15;
    localparam int ACCESS_NS = 50;
    // cycle counts, least times rounded up
    localparam int NV_SAVE_CYC = NV_SAVE_DURATION_MS * (CLK_HZ / 1000);
    localparam int NV_RESTORE_CYC = NV_RESTORE_DURATION_US * (CLK_HZ / 1000000);
    localparam int POWERUP_RESTORE_CYC = POWERUP_RESTORE_DURATION_US * (CLK_HZ / 1000000);
    localparam int INHIBIT_RELEASE_CYC = (INHIBIT_RELEASE_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int BUSY_PULSE_CYC_RAW = (BUSY_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int BUSY_PULSE_CYC = (BUSY_PULSE_CYC_RAW < 1) ? 1 : BUSY_PULSE_CYC_RAW;
    localparam int ACCESS_CYC = (ACCESS_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int CNT_W = 24;
    // software sequence addresses
    localparam logic [12:0] SEQ_A0 = 13'h0000;
    localparam logic [12:0] SEQ_A1 = 13'h1555;
    localparam logic [12:0] SEQ_A2 = 13'h0AAA;
    localparam logic [12:0] SEQ_A3 = 13'h1FFF;
    localparam logic [12:0] SEQ_A4 = 13'h10F0;
    localparam logic [12:0] SEQ_SAVE = 13'h0F0F;
    localparam logic [12:0] SEQ_RESTORE = 13'h0F0E;
    // host commands
    localparam logic [2:0] CMD_READ = 3'h0;
    localparam logic [2:0] CMD_WRITE = 3'h1;
    localparam logic [2:0] CMD_SW_SAVE = 3'h2;
    localparam logic [2:0] CMD_SW_RESTORE = 3'h3;
    localparam logic [2:0] CMD_HW_SAVE = 3'h4;
endpackage : nvc_pkg

// ==== design/nvc_sync.sv ====
// nvc_sync: two-flop synchroniser for pin inputs
// assumes inputs asynchronous to clk_sys
`timescale 1ns/10ps
module nvc_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : nvc_sync

// ==== design/nvc_host.sv ====
// nvc_host: host controller driving a nonvolatile static ram by its pins
// assumes the pins wire straight to the memory; hw_store_busy is open drain
//
// Functional notes
// - host keeps busy pin released high during every write cycle.
// - host holds write strobe high across all six sequence reads.
// - each sequence address is framed by its own chip select pulse.
// - host holds busy pin low at least 15 ns for hardware save.
`timescale 1ns/10ps
module nvc_host
    import nvc_pkg::*;
#(
    parameter int SAVE_CYC = nvc_pkg::NV_SAVE_CYC,
    parameter int POWERUP_CYC = nvc_pkg::POWERUP_RESTORE_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_op,
    input wire logic [nvc_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [nvc_pkg::DATA_W-1:0] cmd_wdata,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [nvc_pkg::DATA_W-1:0] rsp_rdata,
    output logic chip_select_n,
    output logic write_strobe_n,
    output logic output_gate_n,
    output logic [nvc_pkg::ADDR_W-1:0] address_lines,
    input wire logic [nvc_pkg::DATA_W-1:0] data_lines_i,
    output logic [nvc_pkg::DATA_W-1:0] data_lines_o,
    output logic data_lines_oe,
    input wire logic hw_store_busy_n_i,
    output logic hw_store_busy_n_o,
    output logic hw_store_busy_n_oe
);
    import nvc_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef enum logic [7:0] {
        ST_BOOT = 8'h01,
        ST_IDLE = 8'h02,
        ST_ACC = 8'h04,
        ST_GAP = 8'h08,
        ST_BUSY_REQ = 8'h10,
        ST_WAIT = 8'h20,
        ST_RECOV = 8'h40,
        ST_DONE = 8'h80
    } nvc_state_e;

    typedef struct packed {
        nvc_state_e st;
        logic [CNT_W-1:0] cnt;
        logic [2:0] step;
        logic [2:0] op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic cs_n;
        logic we_n;
        logic oe_n;
        logic d_oe;
        logic busy_oe;
        logic ready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
    } nvc_state_s;

    nvc_state_s s_q, s_d;
    logic [DATA_W-1:0] dq_sync;
    logic busy_sync;

    nvc_sync #(.W(DATA_W + 1)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_i({hw_store_busy_n_i, data_lines_i}),
        .sync_o({busy_sync, dq_sync})
    );

    // sequence address for step n
    function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] n, input logic [2:0] op);
        logic [ADDR_W-1:0] a;
        a = SEQ_A0;
        case (n)
            3'h0: a = SEQ_A0;
            3'h1: a = SEQ_A1;
            3'h2: a = SEQ_A2;
            3'h3: a = SEQ_A3;
            3'h4: a = SEQ_A4;
            default: a = (op == CMD_SW_SAVE) ? SEQ_SAVE : SEQ_RESTORE;
        endcase
        return a;
    endfunction : seq_addr

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.rvalid = 1'b0;
        case (s_q.st)
            ST_BOOT: begin
                // wait out power-up restore
                s_d.cnt = s_q.cnt + CNT_W'(1);
                if (s_q.cnt >= CNT_W'(POWERUP_CYC - 1)) begin
                    s_d.st = ST_IDLE;
                    s_d.ready = 1'b1;
                    s_d.cnt = '0;
                end
            end
            ST_IDLE: begin
                if (cmd_valid && s_q.ready) begin
                    s_d.ready = 1'b0;
                    s_d.op = cmd_op;
                    s_d.step = '0;
                    s_d.cnt = '0;
                    s_d.wdata = cmd_wdata;
                    if (cmd_op == CMD_HW_SAVE) begin
                        s_d.st = ST_BUSY_REQ;
                        s_d.busy_oe = 1'b1;
                    end else if (!busy_sync) begin
                        // memory busy on its own (power loss save)
                        s_d.ready = 1'b1;
                    end else begin
                        s_d.st = ST_ACC;
                        s_d.cs_n = 1'b0;
                        if (cmd_op == CMD_WRITE) begin
                            s_d.addr = cmd_addr;
                            s_d.we_n = 1'b0;
                            s_d.d_oe = 1'b1;
                        end else if (cmd_op == CMD_READ) begin
                            s_d.addr = cmd_addr;
                            s_d.oe_n = 1'b0;
                        end else begin
                            // sequence reads, strobe high, gate left high
                            s_d.addr = seq_addr(3'h0, cmd_op);
                        end
                    end
                end
            end
            ST_ACC: begin
                s_d.cnt = s_q.cnt + CNT_W'(1);
                // one extra cycle: read data crosses two sync flops
                if (s_q.cnt >= CNT_W'(ACCESS_CYC + 1)) begin
                    if (s_q.op == CMD_READ) begin
                        s_d.rdata = dq_sync;
                    end
                    s_d.cs_n = 1'b1;
                    s_d.we_n = 1'b1;
                    s_d.oe_n = 1'b1;
                    s_d.d_oe = 1'b0;
                    s_d.cnt = '0;
                    s_d.st = ST_GAP;
                end
            end
            ST_GAP: begin
                s_d.cnt = s_q.cnt + CNT_W'(1);
                if (s_q.cnt >= CNT_W'(ACCESS_CYC)) begin
                    s_d.cnt = '0;
                    if ((s_q.op == CMD_SW_SAVE || s_q.op == CMD_SW_RESTORE) && s_q.step < 3'h5) begin
                        // next sequence step after the chip select gap, no other access between
                        s_d.step = s_q.step + 3'h1;
                        s_d.addr = seq_addr(s_q.step + 3'h1, s_q.op);
                        s_d.cs_n = 1'b0;
                        s_d.st = ST_ACC;
                    end else if (s_q.op == CMD_SW_SAVE || s_q.op == CMD_SW_RESTORE) begin
                        s_d.st = ST_WAIT;
                    end else begin
                        s_d.st = ST_DONE;
                    end
                end
            end
            ST_BUSY_REQ: begin
                s_d.cnt = s_q.cnt + CNT_W'(1);
                if (s_q.cnt >= CNT_W'(BUSY_PULSE_CYC)) begin
                    s_d.busy_oe = 1'b0;
                    s_d.cnt = '0;
                    s_d.st = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // hold off for the operation's full duration
                s_d.cnt = s_q.cnt + CNT_W'(1);
                if (s_q.op == CMD_SW_RESTORE) begin
                    if (s_q.cnt >= CNT_W'(NV_RESTORE_CYC - 1)) begin
                        s_d.cnt = '0;
                        s_d.st = ST_RECOV;
                    end
                end else if (s_q.cnt >= CNT_W'(SAVE_CYC - 1)) begin
                    if (busy_sync) begin
                        s_d.cnt = '0;
                        s_d.st = ST_RECOV;
                    end else begin
                        s_d.cnt = s_q.cnt;
                    end
                end
            end
            ST_RECOV: begin
                s_d.cnt = s_q.cnt + CNT_W'(1);
                if (s_q.cnt >= CNT_W'(INHIBIT_RELEASE_CYC)) begin
                    s_d.cnt = '0;
                    s_d.st = ST_DONE;
                end
            end
            ST_DONE: begin
                s_d.rvalid = 1'b1;
                s_d.ready = 1'b1;
                s_d.st = ST_IDLE;
            end
            default: begin
                s_d.st = ST_IDLE;
                s_d.ready = 1'b1;
            end
        endcase
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_q <= '{st: ST_BOOT, cnt: '0, step: '0, op: CMD_READ, addr: '0, wdata: '0,
                     cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, d_oe: 1'b0, busy_oe: 1'b0,
                     ready: 1'b0, rvalid: 1'b0, rdata: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_comb begin
        cmd_ready = s_q.ready;
        rsp_valid = s_q.rvalid;
        rsp_rdata = s_q.rdata;
        chip_select_n = s_q.cs_n;
        write_strobe_n = s_q.we_n;
        output_gate_n = s_q.oe_n;
        address_lines = s_q.addr;
        data_lines_o = s_q.wdata;
        data_lines_oe = s_q.d_oe;
        hw_store_busy_n_o = 1'b0;
        hw_store_busy_n_oe = s_q.busy_oe;
    end
endmodule : nvc_host

// ==== verification/nvc_host_props.sv ====
// nvc_host_chk: pin and handshake checks on the host controller
// assumes binding to nvc_host, one clock domain
`timescale 1ns/10ps
module nvc_host_chk
    import nvc_pkg::*;
#(
    parameter int SAVE_CYC = 50,
    parameter int POWERUP_CYC = 20
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_op,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic output_gate_n,
    input wire logic [12:0] address_lines,
    input wire logic data_lines_oe,
    input wire logic hw_store_busy_n_i,
    input wire logic hw_store_busy_n_oe
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    logic sw_go;
    logic save_seq_q;
    assign sw_go = cmd_valid && cmd_ready && (cmd_op == CMD_SW_SAVE || cmd_op == CMD_SW_RESTORE);
    // marks a software save in flight
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            save_seq_q <= 1'b0;
        end else if (sw_go && cmd_op == CMD_SW_SAVE) begin
            save_seq_q <= 1'b1;
        end else if (rsp_valid) begin
            save_seq_q <= 1'b0;
        end
    end
    a_write_busy_free: assert property (!chip_select_n && !write_strobe_n |-> !hw_store_busy_n_oe)
        else $error("busy pin pulled during write");
    a_read_strobe_high: assert property (!output_gate_n |-> write_strobe_n && !data_lines_oe)
        else $error("output gate low with strobe or bus drive");
    a_busy_pulse_len: assert property ($rose(hw_store_busy_n_oe) |-> hw_store_busy_n_oe[*2] ##1 !hw_store_busy_n_oe)
        else $error("busy request pulse length wrong");
    a_addr_framed: assert property (!chip_select_n && $past(!chip_select_n) |-> $stable(address_lines))
        else $error("address moved while selected");
    a_seq_no_write: assert property (sw_go |=> write_strobe_n[*8])
        else $error("write strobe low in sequence");
    a_seq_start: assert property (sw_go |-> ##[1:4] (!chip_select_n && address_lines == SEQ_A0))
        else $error("sequence did not start at first address");
    a_busy_hold_off: assert property (!hw_store_busy_n_i [*4] |-> chip_select_n)
        else $error("access while busy pin low");
    a_save_quiet: assert property (save_seq_q && $rose(chip_select_n) && $past(address_lines) == SEQ_SAVE
        |-> chip_select_n[*8])
        else $error("access right after save start");
    c_sw_save: cover property (sw_go && cmd_op == CMD_SW_SAVE);
    c_sw_restore: cover property (sw_go && cmd_op == CMD_SW_RESTORE);
    c_hw_save: cover property ($rose(hw_store_busy_n_oe));
endmodule : nvc_host_chk

bind nvc_host nvc_host_chk #(.SAVE_CYC(SAVE_CYC), .POWERUP_CYC(POWERUP_CYC)) u_nvc_host_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
    .output_gate_n(output_gate_n), .address_lines(address_lines), .data_lines_oe(data_lines_oe),
    .hw_store_busy_n_i(hw_store_busy_n_i), .hw_store_busy_n_oe(hw_store_busy_n_oe));

// ==== verification/nvc_mem_model.sv ====
// nvc_mem_model: behavioural nonvolatile static ram on the host pins
// assumes resolved bus and busy levels come from the bench
`timescale 1ns/10ps
module nvc_mem_model
    import nvc_pkg::*;
#(
    parameter int T_SAVE = 1500,
    parameter int T_RESTORE = 5000
) (
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic output_gate_n,
    input wire logic [12:0] address_lines,
    input wire logic [7:0] data_lines,
    input wire logic hw_store_busy_n,
    input wire logic supply_drop,
    output logic [7:0] dq_o,
    output logic dq_oe,
    output logic busy_oe
);
    logic [7:0] sram [0:8191];
    logic [7:0] nv [0:8191];
    logic [12:0] seq_tab [0:4] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
    logic dirty = 0;
    logic op_run = 1;
    logic w_at_cs = 0;
    logic wr_act;
    logic [12:0] wa;
    logic [7:0] wd;
    int step = 0;
    assign wr_act = !chip_select_n && !write_strobe_n && hw_store_busy_n && !op_run;
    assign dq_oe = !chip_select_n && !output_gate_n && write_strobe_n && hw_store_busy_n && !op_run && !w_at_cs;
    assign dq_o = sram[address_lines];
    initial begin
        busy_oe = 1'b0;
        foreach (nv[i]) nv[i] = 8'h00;
        #500 sram = nv;
        op_run = 0;
    end
    task automatic nv_op(input logic save);
        step = 0;
        op_run = 1;
        if (!save) foreach (sram[i]) sram[i] = 8'h00;
        if (save) #(T_SAVE) nv = sram;
        else #(T_RESTORE) sram = nv;
        dirty = 0;
        op_run = 0;
    endtask : nv_op
    always @(negedge chip_select_n) w_at_cs = !write_strobe_n;
    // latch after the strobe edge so release order cannot race
    always @(posedge wr_act) #5 {wa, wd} = {address_lines, data_lines};
    always @(negedge wr_act) begin
        sram[wa] = wd;
        dirty = 1;
        step = 0;
    end
    always @(negedge chip_select_n) begin
        #1;
        if (write_strobe_n && hw_store_busy_n && !op_run) begin
            if (step == 5 && (address_lines == SEQ_SAVE || address_lines == SEQ_RESTORE)) nv_op(address_lines == SEQ_SAVE);
            else if (step < 5 && address_lines == seq_tab[step]) step++;
            else step = (address_lines == SEQ_A0);
        end
    end
    always @(negedge hw_store_busy_n) begin
        if (!op_run) begin
            op_run = 1;
            #200 busy_oe = 1;
            #1000;
            if (dirty) #(T_SAVE) nv = sram;
            dirty = 0;
            busy_oe = 0;
            wait (hw_store_busy_n);
            #500 op_run = 0;
        end
    end
    // power loss: busy pulse, save only when dirty
    always @(posedge supply_drop) begin
        if (!op_run) begin
            op_run = 1;
            busy_oe = 1;
            #1000;
            if (dirty) #(T_SAVE) nv = sram;
            dirty = 0;
            busy_oe = 0;
            op_run = 0;
        end
    end
endmodule : nvc_mem_model

// ==== verification/tb_top.sv ====
// tb_top: self-checking bench for the host controller and memory model
// assumes pull-up on the busy pin and a floating data bus
`timescale 1ns/10ps
module tb_top;
    import nvc_pkg::*;
    logic clk_sys = 0;
    logic rst_n = 0;
    logic cmd_valid = 0;
    logic [2:0] cmd_op = 3'h0;
    logic [12:0] cmd_addr = 13'h0000;
    logic [12:0] a;
    logic [12:0] address_lines;
    logic [7:0] cmd_wdata = 8'h00;
    logic [7:0] bus_last = 8'h00;
    logic [7:0] rsp_rdata, data_lines_o, mem_dq, bus, d1, d2;
    logic cmd_ready, rsp_valid, chip_select_n, write_strobe_n, output_gate_n, data_lines_oe;
    logic busy_o, busy_oe, mem_dq_oe, mem_busy_oe, busy_pin;
    logic [8:0] notes [$];
    logic [8:0] note;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    int low_cyc = 0;
    logic supply_drop = 1'b0;
    localparam int LOSS_CYC = CLK_HZ / 1000000;
    always #25 clk_sys = ~clk_sys;
    assign bus = data_lines_oe ? data_lines_o : (mem_dq_oe ? mem_dq : ~bus_last);
    assign busy_pin = !((busy_oe && !busy_o) || mem_busy_oe);
    always @(posedge clk_sys) if (data_lines_oe || mem_dq_oe) bus_last <= bus;
    nvc_host #(.SAVE_CYC(50), .POWERUP_CYC(20)) u_nvc_host (.clk_sys(clk_sys), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
        .output_gate_n(output_gate_n), .address_lines(address_lines), .data_lines_i(bus), .data_lines_o(data_lines_o),
        .data_lines_oe(data_lines_oe), .hw_store_busy_n_i(busy_pin), .hw_store_busy_n_o(busy_o),
        .hw_store_busy_n_oe(busy_oe));
    nvc_mem_model u_nvc_mem_model (.chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
        .output_gate_n(output_gate_n), .address_lines(address_lines), .data_lines(bus),
        .hw_store_busy_n(busy_pin), .supply_drop(supply_drop), .dq_o(mem_dq), .dq_oe(mem_dq_oe),
        .busy_oe(mem_busy_oe));
    task automatic summarize();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    task automatic issue(input logic [2:0] op, input logic [12:0] ad, input logic [7:0] wd, input logic chk);
        notes.push_back({chk, wd});
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= ad;
        cmd_wdata <= wd;
        do @(posedge clk_sys); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        while (rsp_valid !== 1'b1) @(posedge clk_sys);
    endtask : issue
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles > 5000) begin
            mismatches++;
            summarize();
        end else if (rsp_valid === 1'b1 && notes.size() > 0) begin
            note = notes.pop_front();
            tests_run += note[8];
            if (note[8] && rsp_rdata !== note[7:0]) begin
                mismatches++;
                $display("Error rsp_rdata expected %h seen %h", note[7:0], rsp_rdata);
            end
        end
    end
    initial begin
        void'($urandom(66));
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            a = 13'($urandom);
            d1 = 8'($urandom);
            issue(CMD_WRITE, a, d1, 1'b0);
            issue(CMD_READ, a, d1, 1'b1);
        end
        d2 = d1 ^ 8'hFF;
        issue(CMD_SW_SAVE, 13'h0000, 8'h00, 1'b0);
        issue(CMD_WRITE, a, d2, 1'b0);
        issue(CMD_READ, a, d2, 1'b1);
        issue(CMD_SW_RESTORE, 13'h0000, 8'h00, 1'b0);
        issue(CMD_READ, a, d1, 1'b1);
        issue(CMD_WRITE, a, d2, 1'b0);
        issue(CMD_HW_SAVE, 13'h0000, 8'h00, 1'b0);
        issue(CMD_WRITE, a, d1, 1'b0);
        issue(CMD_SW_RESTORE, 13'h0000, 8'h00, 1'b0);
        issue(CMD_READ, a, d2, 1'b1);
        supply_drop <= 1'b1;
        @(posedge clk_sys);
        supply_drop <= 1'b0;
        low_cyc = 0;
        while (busy_pin !== 1'b1) begin
            @(posedge clk_sys);
            low_cyc++;
        end
        tests_run++;
        if (low_cyc < LOSS_CYC - 2 || low_cyc > LOSS_CYC + 2) begin
            mismatches++;
            $display("Error busy_low_cycles expected %0d seen %0d", LOSS_CYC, low_cyc);
        end
        repeat (2) @(posedge clk_sys);
        issue(CMD_READ, a, d2, 1'b1);
        @(posedge clk_sys);
        summarize();
    end
endmodule : tb_top
